// ==== core/serial_iq_output_port.sv ====
// Serial I/Q output port with APB control and shared framing
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module serial_iq_output_port
  import iq_port_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Filtered sample pair from the receive channels
  input  wire logic              sample_valid,
  input  wire sample_t           sample,
  output logic                   sample_ready,
  // Serial link pins
  output serial_pins_t           pins
);

  typedef struct packed {
    ctrl_t                ctrl;
    logic [31:0]          prdata;
    logic                 pending;
    sample_t              buf_data;
    port_state_t          state;
    ctrl_t                frame_cfg;
    logic [SHIFT_W-1:0]   sh_a;
    logic [SHIFT_W-1:0]   sh_b;
    logic [CNT_W-1:0]     bit_cnt;
    logic                 fs_out;
    logic                 fs_smp;
    logic                 d_a;
    logic                 d_b;
    logic                 oe_n;
  } port_reg_t;

  port_reg_t s_r;
  port_reg_t s_nxt;

  logic             sclk;
  logic             rise;
  logic             fall;
  logic             setup;
  logic             access;
  logic             hit_ctrl;
  logic             hit_stat;
  logic [31:0]      status;
  logic             can_start;
  logic [CNT_W-1:0] word_len;
  logic [CNT_W-1:0] last_bit;
  logic             fs_held;
  logic             fs_twice;
  logic             last_step;
  logic             mid_step;
  logic [31:0]      rd_mux;

  logic [SHIFT_W-1:0] load_a;
  logic [SHIFT_W-1:0] load_b;

  // Divider writes act at once; change it only while no frame runs
  sclk_divider u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .div     (s_r.ctrl.serial_clock_divider),
    .sclk    (sclk),
    .rise    (rise),
    .fall    (fall)
  );

  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign hit_ctrl = (paddr == CTRL_ADDR);
  assign hit_stat = (paddr == STAT_ADDR);

  always_comb begin
    status                 = 32'h0;
    status[ST_PENDING_BIT] = s_r.pending;
    status[ST_ACTIVE_BIT]  = (s_r.state != ST_IDLE);
    status[ST_MASTER_BIT]  = s_r.ctrl.bus_master_select;
  end

  // Read mux; registered in the setup cycle so prdata leaves a flip-flop
  always_comb begin
    rd_mux = 32'h0;
    if (hit_ctrl) begin
      rd_mux = {24'h0, s_r.ctrl};
    end else if (hit_stat) begin
      rd_mux = status;
    end
  end

  // start only with a loaded pair
  assign can_start = s_r.pending && s_r.ctrl.bus_master_select;

  // word length of the running frame
  assign word_len = s_r.frame_cfg.long_word ? CNT_W'(SAMPLE_W)
                                            : CNT_W'(SHORT_W);
  assign last_bit = CNT_W'({word_len, 1'b0} - 7'h1);

  // Framing style of the running frame; codes 00 and 01 act alike
  assign fs_held  = (s_r.frame_cfg.fs_mode == FS_HELD);
  assign fs_twice = (s_r.frame_cfg.fs_mode == FS_TWICE);

  // Last bit of the frame, and the bit before the last I bit
  assign last_step = (s_r.bit_cnt == last_bit);
  assign mid_step  = (s_r.bit_cnt == word_len - CNT_W'(2));

  // Left-align both words; short words keep the upper bits
  function automatic logic [SHIFT_W-1:0] pack_words(
    input logic                long_w,
    input logic [SAMPLE_W-1:0] iw,
    input logic [SAMPLE_W-1:0] qw
  );
    logic [SHIFT_W-1:0] r;
    r = '0;
    if (long_w) begin
      r = {iw, qw};
    end else begin
      r = {iw[SAMPLE_W-1 -: SHORT_W], qw[SAMPLE_W-1 -: SHORT_W],
           {(SHIFT_W - 2*SHORT_W){1'b0}}};
    end
    return r;
  endfunction

  always_comb begin
    load_a = '0;
    load_b = '0;
    if (s_r.ctrl.chan_map) begin
      load_a = pack_words(s_r.ctrl.long_word,
                          s_r.buf_data.i_a, s_r.buf_data.q_a);
      load_b = pack_words(s_r.ctrl.long_word,
                          s_r.buf_data.i_b, s_r.buf_data.q_b);
    end else begin
      load_a = pack_words(s_r.ctrl.long_word,
                          s_r.buf_data.i_b, s_r.buf_data.q_b);
      load_b = pack_words(s_r.ctrl.long_word,
                          s_r.buf_data.i_a, s_r.buf_data.q_a);
    end
  end

  always_comb begin
    s_nxt = s_r;

    // Register writes take effect in the access phase only
    if (access && pwrite && hit_ctrl) begin
      s_nxt.ctrl = ctrl_t'(pwdata[7:0]);
    end
    // Read data prepared in setup so it leaves a flip-flop
    if (setup) begin
      s_nxt.prdata = rd_mux;
    end

    // one pair buffered until a frame takes it
    if (sample_valid && !s_r.pending) begin
      s_nxt.pending  = 1'b1;
      s_nxt.buf_data = sample;
    end

    // frame sync seen on the falling serial edge
    if (fall) begin
      s_nxt.fs_smp = s_r.fs_out;
    end

    if (rise) begin
      unique case (s_r.state)
        ST_IDLE: begin
          s_nxt.oe_n   = 1'b1;
          s_nxt.fs_out = 1'b0;
          if (can_start) begin
            s_nxt.state = ST_SYNC;
          end
        end
        ST_SYNC: begin
          // frame begins at the rise after the sample
          if (s_nxt.fs_smp) begin
            s_nxt.state   = ST_SHIFT;
            s_nxt.bit_cnt = '0;
            s_nxt.oe_n    = 1'b0;
            s_nxt.d_a     = s_r.sh_a[SHIFT_W-1];
            s_nxt.d_b     = s_r.sh_b[SHIFT_W-1];
            s_nxt.sh_a    = {s_r.sh_a[SHIFT_W-2:0], 1'b0};
            s_nxt.sh_b    = {s_r.sh_b[SHIFT_W-2:0], 1'b0};
            // sync stays high over the data in held mode only
            s_nxt.fs_out  = fs_held;
          end else begin
            s_nxt.state  = ST_IDLE;
            s_nxt.fs_out = 1'b0;
          end
        end
        ST_SHIFT: begin
          if (last_step) begin
            s_nxt.oe_n   = 1'b1;
            s_nxt.fs_out = 1'b0;
            s_nxt.state  = ST_IDLE;
            if (can_start) begin
              s_nxt.state = ST_SYNC;
            end
          end else begin
            // one bit per clock, Q after I
            s_nxt.bit_cnt = s_r.bit_cnt + CNT_W'(1);
            s_nxt.d_a     = s_r.sh_a[SHIFT_W-1];
            s_nxt.d_b     = s_r.sh_b[SHIFT_W-1];
            s_nxt.sh_a    = {s_r.sh_a[SHIFT_W-2:0], 1'b0};
            s_nxt.sh_b    = {s_r.sh_b[SHIFT_W-2:0], 1'b0};
            if (fs_held) begin
              // held to the last Q bit
              s_nxt.fs_out = 1'b1;
            end else if (fs_twice) begin
              // second pulse during the last I bit
              s_nxt.fs_out = mid_step;
            end else begin
              s_nxt.fs_out = 1'b0;
            end
          end
        end
        default: begin
          // Illegal state code; fall back to idle with outputs released
          s_nxt.state  = ST_IDLE;
          s_nxt.oe_n   = 1'b1;
          s_nxt.fs_out = 1'b0;
        end
      endcase

      // Load on entry to sync; one shared config for both outputs
      if (s_nxt.state == ST_SYNC && s_r.state != ST_SYNC) begin
        // sync pulse one full clock before data
        s_nxt.fs_out    = 1'b1;
        // frame config shared by both outputs
        s_nxt.frame_cfg = s_r.ctrl;
        s_nxt.pending   = 1'b0;
        s_nxt.sh_a = load_a;
        s_nxt.sh_b = load_b;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r           <= '0;
      s_r.ctrl      <= ctrl_t'(CTRL_RESET);
      s_r.frame_cfg <= ctrl_t'(CTRL_RESET);
      s_r.state     <= ST_IDLE;
      s_r.oe_n      <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready       = 1'b1;
  assign pslverr      = access && !(hit_ctrl || hit_stat);
  assign prdata       = s_r.prdata;
  // Freed the cycle after a frame takes the pair
  assign sample_ready = !s_r.pending;

  // outputs change with serial rise only
  always_comb begin
    pins                        = '0;
    pins.serial_clock           = sclk;
    pins.frame_sync_out         = s_r.fs_out;
    pins.serial_data_out_a      = s_r.d_a;
    pins.serial_data_out_b      = s_r.d_b;
    pins.serial_data_out_a_oe_n = s_r.oe_n;
    pins.serial_data_out_b_oe_n = s_r.oe_n;
  end

endmodule // serial_iq_output_port
`default_nettype wire

// ==== core/iq_port_pkg.sv ====
// Constants, field layout and carrier types of the serial I/Q output port
package iq_port_pkg;

  // Clocking
  localparam int unsigned PCLK_MHZ     = 40;
  localparam int unsigned SCLK_MAX_MHZ = 52;
  // Least divide ratio that keeps the serial clock under its ceiling
  localparam int unsigned MIN_RATIO    =
    (PCLK_MHZ + SCLK_MAX_MHZ - 1) / SCLK_MAX_MHZ;
  localparam logic [2:0]  MIN_DIV      = 3'(MIN_RATIO - 1);

  // Word sizes
  localparam int unsigned SAMPLE_W = 24;
  localparam int unsigned SHORT_W  = 16;
  localparam int unsigned SHIFT_W  = 2 * SAMPLE_W;
  localparam int unsigned CNT_W    = 6;

  // Register map: printed offsets are indices, byte address is four times
  localparam int unsigned ADDR_W     = 12;
  localparam logic [7:0]  CTRL_IDX   = 8'h21;
  localparam logic [7:0]  STAT_IDX   = 8'h22;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};

  // Control reset: bus master, channel A on output a, mode 00, 16 bits
  localparam logic [7:0]  CTRL_RESET = 8'h88;

  // Status field positions
  localparam int unsigned ST_PENDING_BIT = 0;
  localparam int unsigned ST_ACTIVE_BIT  = 1;
  localparam int unsigned ST_MASTER_BIT  = 2;

  // Frame sync mode codes
  localparam logic [1:0]  FS_TWICE = 2'h2;
  localparam logic [1:0]  FS_HELD  = 2'h3;

  typedef struct packed {
    logic       chan_map;
    logic [1:0] fs_mode;
    logic       long_word;
    logic       bus_master_select;
    logic [2:0] serial_clock_divider;
  } ctrl_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] i_a;
    logic [SAMPLE_W-1:0] q_a;
    logic [SAMPLE_W-1:0] i_b;
    logic [SAMPLE_W-1:0] q_b;
  } sample_t;

  typedef struct packed {
    logic serial_clock;
    logic frame_sync_out;
    logic serial_data_out_a;
    logic serial_data_out_a_oe_n;
    logic serial_data_out_b;
    logic serial_data_out_b_oe_n;
  } serial_pins_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SYNC,
    ST_SHIFT
  } port_state_t;

endpackage

// ==== core/sclk_divider.sv ====
// Serial clock divider with rise and fall tick outputs
`timescale 1ns/100ps
`default_nettype none
module sclk_divider
  import iq_port_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Divider word
  input  wire logic [2:0] div,
  // Serial clock and edge ticks
  output logic            sclk,
  output logic            rise,
  output logic            fall
);

  typedef struct packed {
    logic [2:0] cnt;
    logic       sclk;
  } div_state_t;

  div_state_t s_r;
  div_state_t s_nxt;
  logic [2:0] div_eff;
  logic [2:0] half;

  assign div_eff = (div < MIN_DIV) ? MIN_DIV : div;
  assign half    = 3'((4'(div_eff) + 4'h2) >> 1);

  always_comb begin
    s_nxt = s_r;
    if (s_r.cnt >= div_eff) begin
      s_nxt.cnt = 3'h0;
    end else begin
      s_nxt.cnt = s_r.cnt + 3'h1;
    end
    s_nxt.sclk = (s_nxt.cnt < half);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Next edge is a serial rise or fall; ratio one is pclk itself
  assign rise = (s_r.cnt >= div_eff);
  assign fall = (div_eff == 3'h0) || (s_r.sclk && !s_nxt.sclk);
  assign sclk = (div_eff == 3'h0) ? pclk : s_r.sclk;

endmodule // sclk_divider
`default_nettype wire

// ==== tb/serial_iq_output_port_asserts.sv ====
// Concurrent checks on the serial I/Q output port pins
`timescale 1ns/100ps
`default_nettype none
module serial_iq_output_port_asserts
  import iq_port_pkg::*;
(
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              pready,
  input wire logic              pslverr,
  // Samples and link
  input wire logic              sample_valid,
  input wire logic              sample_ready,
  input wire serial_pins_t      pins
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable;

  no_wait_a: assert property (acc |-> pready)
    else $error("pready low in access");
  unmapped_err_a: assert property (acc && paddr != CTRL_ADDR
    && paddr != STAT_ADDR |-> pslverr) else $error("no slave error");
  oe_pair_a: assert property (pins.serial_data_out_a_oe_n
    == pins.serial_data_out_b_oe_n) else $error("enables differ");
  fs_on_rise_a: assert property ($changed(pins.frame_sync_out)
    |-> $rose(pins.serial_clock)) else $error("sync off serial rise");
  data_on_rise_a: assert property (!$rose(pins.serial_clock)
    |-> $stable(pins.serial_data_out_a) && $stable(pins.serial_data_out_b))
    else $error("data off rise");
  sync_first_a: assert property ($fell(pins.serial_data_out_a_oe_n)
    |-> $past(pins.frame_sync_out)) else $error("no sync before data");
  ready_drop_a: assert property (sample_valid && sample_ready
    |=> !sample_ready) else $error("ready stays after take");
  pair_first_a: assert property ($rose(pins.frame_sync_out) &&
    pins.serial_data_out_a_oe_n |-> !$past(sample_ready))
    else $error("frame without pair");

  cover property ($fell(pins.serial_data_out_a_oe_n));
  cover property (acc && pslverr);
  cover property (sample_valid && sample_ready);
endmodule // serial_iq_output_port_asserts

bind serial_iq_output_port serial_iq_output_port_asserts chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .sample_valid(sample_valid), .sample_ready(sample_ready), .pins(pins));
`default_nettype wire

// ==== tb/iq_receiver_model.sv ====
// Model of the DSP serial receive input on the far side
`timescale 1ns/100ps
`default_nettype none
module iq_receiver_model
  import iq_port_pkg::*;
(
  // Link from the port
  input  wire serial_pins_t  pins,
  // Last captured frame
  output logic [SHIFT_W-1:0] word_a = '0,
  output logic [SHIFT_W-1:0] word_b = '0,
  output int                 nbits = 0,
  output int                 fs_cnt = 0,
  output int                 frames = 0
);
  logic [SHIFT_W-1:0] sh_a = '0;
  logic [SHIFT_W-1:0] sh_b = '0;
  int                 n = 0;
  int                 fsn = 0;
  always @(negedge pins.serial_clock) begin
    if (!pins.serial_data_out_a_oe_n) begin
      sh_a <= {sh_a[SHIFT_W-2:0], pins.serial_data_out_a};
      sh_b <= {sh_b[SHIFT_W-2:0], pins.serial_data_out_b};
      n <= n + 1;
      fsn <= fsn + int'(pins.frame_sync_out);
    end else if (n != 0) begin
      // Output enable release marks the end of a frame
      word_a <= sh_a;
      word_b <= sh_b;
      nbits <= n;
      fs_cnt <= fsn;
      frames <= frames + 1;
      n <= 0;
      fsn <= int'(pins.frame_sync_out);
    end else begin
      fsn <= fsn + int'(pins.frame_sync_out);
    end
  end
endmodule // iq_receiver_model
`default_nettype wire

// ==== tb/serial_iq_output_port_bench.sv ====
// Self-checking bench of the serial I/Q output port
`timescale 1ns/100ps
`default_nettype none
module serial_iq_output_port_bench
  import iq_port_pkg::*;
;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [ADDR_W-1:0]  paddr = '0;
  logic [31:0]        pwdata = '0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               sample_valid = 1'b0;
  sample_t            sample = '0;
  logic               sample_ready;
  serial_pins_t       pins;
  logic [SHIFT_W-1:0] word_a;
  logic [SHIFT_W-1:0] word_b;
  int                 nbits, fs_cnt, frames;
  int                 err_total = 0;
  int                 comparisons = 0;
  logic [31:0]        rd;
  logic               err;

  always #12.5 pclk = ~pclk;

  serial_iq_output_port dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .sample(sample),
    .sample_ready(sample_ready), .pins(pins));
  iq_receiver_model far (.pins(pins), .word_a(word_a), .word_b(word_b),
    .nbits(nbits), .fs_cnt(fs_cnt), .frames(frames));

  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Ready is read settled, before the edge that takes the pair
  task automatic offer(input sample_t s);
    logic rdy;
    @(posedge pclk);
    sample_valid <= 1'b1;
    sample <= s;
    do begin
      #1 rdy = sample_ready;
      @(posedge pclk);
    end while (rdy !== 1'b1);
    sample_valid <= 1'b0;
  endtask

  // Short words carry the upper 16 bits of each sample
  function automatic logic [SHIFT_W-1:0] pick(logic l, logic [23:0] i,
                                              logic [23:0] q);
    return l ? {i, q} : {16'h0, i[23:8], q[23:8]};
  endfunction

  task automatic expect_frame(input logic [7:0] c, input sample_t s,
                              input logic wr, input logic off);
    int                 k, w, f0;
    time                t0;
    logic [SHIFT_W-1:0] m;
    w = c[4] ? 24 : 16;
    m = c[4] ? '1 : 48'hffff_ffff;
    f0 = frames;
    if (wr) apb(1'b1, CTRL_ADDR, {24'h0, c});
    if (off) offer(s);
    @(posedge pins.serial_clock);
    t0 = $time;
    @(posedge pins.serial_clock);
    check($time - t0 == 25 * (c[2:0] + 1), "sclk period");
    while (frames == f0) begin
      @(posedge pclk);
    end
    check(nbits == 2 * w, "bit count");
    check((word_a & m) === pick(c[4], c[7] ? s.i_a : s.i_b,
      c[7] ? s.q_a : s.q_b), "word a");
    check((word_b & m) === pick(c[4], c[7] ? s.i_b : s.i_a,
      c[7] ? s.q_b : s.q_a), "word b");
    k = c[6:5] == FS_HELD ? 1 + 2 * w : c[6:5] == FS_TWICE ? 2 : 1;
    check(fs_cnt == k, "sync count");
  endtask

  task automatic t_regs();
    apb(1'b0, CTRL_ADDR, '0);
    check(rd === 32'h88, "control reset");
    apb(1'b1, CTRL_ADDR, 32'hffff_ff3b);
    apb(1'b1, STAT_ADDR, 32'hff);
    check(err === 1'b0, "status write");
    apb(1'b0, STAT_ADDR, '0);
    check(rd === 32'h4, "status idle");
    apb(1'b0, 12'h0fc, '0);
    check(err === 1'b1 && rd === '0, "unmapped read");
    apb(1'b1, 12'h080, '0);
    check(err === 1'b1, "unmapped write");
    apb(1'b0, CTRL_ADDR, '0);
    check(rd === 32'h3b && err === 1'b0, "control readback");
    $display("test regs done");
  endtask

  task automatic t_idle();
    sample_t s;
    int      f0;
    s = '{24'h7f0011, 24'h800001, 24'h123456, 24'hfedcba};
    apb(1'b1, CTRL_ADDR, 32'h81);
    f0 = frames;
    offer(s);
    repeat (300) @(posedge pclk);
    check(frames == f0, "frame without master");
    apb(1'b0, STAT_ADDR, '0);
    check(rd === 32'h1, "status pending");
    check(pins.serial_data_out_a_oe_n === 1'b1, "a driven");
    check(pins.frame_sync_out === 1'b0, "sync while idle");
    expect_frame(8'h89, s, 1'b1, 1'b0);
    $display("test idle done");
  endtask

  task automatic t_frames();
    logic [7:0] tbl [4] = '{8'h3b, 8'hcf, 8'hfa, 8'h5c};
    sample_t    s;
    foreach (tbl[j]) begin
      s = '{24'h9b2d41 + 24'(j), 24'h36e7c5, 24'hc1048f ^ 24'(j), 24'h5fa213};
      expect_frame(tbl[j], s, 1'b1, 1'b1);
    end
    $display("test frames done");
  endtask

  task automatic t_back();
    sample_t s1, s2;
    s1 = '{24'h800000, 24'h7fffff, 24'h000001, 24'hffffff};
    s2 = '{24'h5a5a5a, 24'ha5a5a5, 24'h0f0f0f, 24'hf0f0f0};
    apb(1'b1, CTRL_ADDR, 32'hf9);
    offer(s1);
    offer(s2);
    expect_frame(8'hf9, s1, 1'b0, 1'b0);
    expect_frame(8'hf9, s2, 1'b0, 1'b0);
    $display("test back to back done");
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    results();
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_idle();
    t_frames();
    t_back();
    results();
  end
endmodule // serial_iq_output_port_bench
`default_nettype wire
